// ===== irq_error_pkg.sv
// shared offsets, bit positions, reset values and codes for the irq and error flag unit
package irq_error_pkg;

    // register offsets as printed
    localparam logic [7:0] core_event_flags_addr   = 8'h06;
    localparam logic [7:0] timer_event_flags_addr  = 8'h07;
    localparam logic [7:0] core_event_enable_addr  = 8'h08;
    localparam logic [7:0] timer_event_enable_addr = 8'h09;
    localparam logic [7:0] receive_error_addr      = 8'h0a;

    // write convention: bit 7 picks set or clear
    localparam int set_dir_bit = 7;

    // timer event flags / enables
    localparam int global_bit      = 6;
    localparam int card_detect_bit = 5;
    localparam int timer_count     = 5;
    localparam int timer_flag_bits = 6;
    localparam int pin_style_bit   = 7;
    localparam int pin_enable_bit  = 6;

    // core event flags / enables
    localparam int core_flag_bits    = 7;
    localparam int high_alert_bit    = 6;
    localparam int low_alert_bit     = 5;
    localparam int command_done_bit  = 4;
    localparam int transmit_done_bit = 3;
    localparam int receive_done_bit  = 2;
    localparam int error_request_bit = 1;
    localparam int frame_start_bit   = 0;
    localparam int polarity_bit      = 7;

    // receive error register
    localparam int nvm_error_bit     = 7;
    localparam int illegal_write_bit = 6;
    localparam int overflow_bit      = 5;
    localparam int short_frame_bit   = 4;
    localparam int no_data_bit       = 3;
    localparam int collision_bit     = 2;
    localparam int protocol_bit      = 1;
    localparam int integrity_bit     = 0;

    // reset values
    localparam logic [7:0] enable_reset = 8'h00;
    localparam logic [7:0] error_reset  = 8'h00;
    localparam logic [7:0] rdata_reset  = 8'h00;

    // transceiver state codes
    localparam logic [2:0] state_rx_wait   = 3'h5;
    localparam logic [2:0] state_wait_data = 3'h6;
    localparam logic [2:0] state_receiving = 3'h7;

    // least frame lengths, in received bits
    localparam int          bit_count_width  = 13;
    localparam logic [12:0] min_frame_bits   = 13'h0004;
    localparam logic [12:0] min_frame_bits_s = 13'h0018;

endpackage

// ===== flag_set_clear.sv
// sticky flag bank with set/clear write convention, hardware set wins
`timescale 1ns/10ps
module flag_set_clear #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // software write
    input  wire logic             wr_i,
    input  wire logic [WIDTH-1:0] mask_i,
    input  wire logic             set_dir_i,
    // hardware events
    input  wire logic [WIDTH-1:0] hw_set_i,
    // flags
    output logic      [WIDTH-1:0] flag_o
);

    logic [WIDTH-1:0] sw_set;
    logic [WIDTH-1:0] sw_clr;

    assign sw_set = (wr_i && set_dir_i) ? mask_i : '0;
    assign sw_clr = (wr_i && !set_dir_i) ? mask_i : '0;

    // an event in the clearing cycle survives
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= (flag_o & ~sw_clr) | sw_set | hw_set_i;
        end
    end

endmodule // flag_set_clear

// ===== irq_pin_driver.sv
// interrupt pin level and drive style
`timescale 1ns/10ps
module irq_pin_driver (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic global_i,
    input  wire logic pin_enable_i,
    input  wire logic invert_i,
    input  wire logic push_pull_i,
    // pin
    output logic      pin_o,
    output logic      pin_oe_o
);

    logic level;

    assign level = (global_i && pin_enable_i) ^ invert_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o    <= level;
            // open drain only pulls low, the high level comes from the pull-up
            pin_oe_o <= push_pull_i || !level;
        end
    end

endmodule // irq_pin_driver

// ===== irq_error_unit.sv
// interrupt aggregation, interrupt pin and error flag register
//
// Contract
// R1: timer flags set/cleared by bit 7 write
// R2: global flag when any enabled request active
// R3: card detection sets card-detect flag
// R4: each timer underflow sets own flag
// R5: polarity bit inverts interrupt pin
// R6: core enables gate core request flags
// R7: timer enables gate card and timer flags
// R8: style bit selects push-pull or open-drain
// R9: pin enable gates global flag to pin
// R10: failed nonvolatile command sets nvm error
// R11: fifo write in busy phases flags error
// R12: illegal write clears on command start; in multi-frame receive the code clears it on errors-to-fifo instead
// R13: overflow on full write, discard later writes
// R14: short frame after valid start sets flag
// R15: short frames dropped, no receive-done raised
// R16: short-frame flag clears at receive phase
// R17: transmit with empty fifo sets no-data
// R18: error sources set error request flag; the code uses illegal write, overflow, protocol, no-data and integrity only
// R19: core flags use same set/clear write
// R20: pin level is gated global xor polarity
`timescale 1ns/10ps
module irq_error_unit (
    // clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        ARST_N_I,
    // register port
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [7:0]  RDATA_O,
    // core event pulses
    input  wire logic        HIGH_ALERT_I,
    input  wire logic        LOW_ALERT_I,
    input  wire logic        COMMAND_DONE_I,
    input  wire logic        TRANSMIT_DONE_I,
    input  wire logic        FRAME_START_I,
    // timer and card detection pulses
    input  wire logic        CARD_DETECT_I,
    input  wire logic [4:0]  TIMER_UNDERFLOW_I,
    // nonvolatile memory command end
    input  wire logic        NVM_CMD_END_I,
    input  wire logic        NVM_CMD_ERROR_I,
    // fifo side
    input  wire logic        FIFO_WRITE_I,
    input  wire logic        FIFO_FULL_I,
    input  wire logic        FIFO_EMPTY_I,
    output logic             FIFO_WRITE_ACCEPT_O,
    // command and transceiver state
    input  wire logic        CMD_START_I,
    input  wire logic        RECEIVE_CMD_START_I,
    input  wire logic        TRANSCEIVE_I,
    input  wire logic        AUTH_CMD_I,
    input  wire logic        CRC_TX_I,
    input  wire logic [2:0]  COM_STATE_I,
    input  wire logic        TX_REQUEST_I,
    input  wire logic        MULTI_FRAME_RECEIVE_I,
    input  wire logic        ERRORS_TO_FIFO_I,
    // receiver results
    input  wire logic        FRAME_END_I,
    input  wire logic        SOF_VALID_I,
    input  wire logic [12:0] FRAME_BITS_I,
    input  wire logic        DISTURBANCE_SUPPRESSION_I,
    input  wire logic        COLLISION_I,
    input  wire logic        PROTOCOL_ERROR_I,
    input  wire logic        INTEGRITY_ERROR_I,
    output logic             FRAME_DROP_O,
    // interrupt pin
    output logic             IRQ_PIN_O,
    output logic             IRQ_PIN_OE_O
);

    // register file
    logic [7:0] core_event_enable;
    logic [7:0] timer_event_enable_pin_ctrl;
    logic [7:0] receive_error_flags;
    logic [6:0] core_flags;
    logic [5:0] timer_flags;
    logic       global_interrupt_flag;

    // write decode
    logic wr_core_flags;
    logic wr_timer_flags;
    logic wr_core_enable;
    logic wr_timer_enable;

    // derived events
    logic       frame_short;
    logic       frame_drop;
    logic       receive_done_event;
    logic       illegal_state;
    logic [7:0] error_set;
    logic [7:0] error_clr;
    logic       rx_phase_clear;
    logic       illegal_clear;
    logic [2:0] prev_state;
    logic [6:0] core_hw_set;
    logic [5:0] timer_hw_set;
    logic [4:0] error_request_src;

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        addr_hit = (addr == target);
    endfunction

    assign wr_core_flags   = WR_I && addr_hit(ADDR_I, irq_error_pkg::core_event_flags_addr);
    assign wr_timer_flags  = WR_I && addr_hit(ADDR_I, irq_error_pkg::timer_event_flags_addr);
    assign wr_core_enable  = WR_I && addr_hit(ADDR_I, irq_error_pkg::core_event_enable_addr);
    assign wr_timer_enable = WR_I && addr_hit(ADDR_I, irq_error_pkg::timer_event_enable_addr);

    // frame length checks
    always_comb begin
        frame_short = FRAME_BITS_I < irq_error_pkg::min_frame_bits;
        frame_drop  = FRAME_END_I && (frame_short
                      || (DISTURBANCE_SUPPRESSION_I
                      && (FRAME_BITS_I < irq_error_pkg::min_frame_bits_s))); // R15
    end

    // decoder keeps running; the drop is only reported
    assign FRAME_DROP_O       = frame_drop; // R15
    assign receive_done_event = FRAME_END_I && !frame_drop; // R15

    // fifo writes while receiving, sending crc or running an auth command are not legal
    assign illegal_state = CRC_TX_I || AUTH_CMD_I
                           || (COM_STATE_I == irq_error_pkg::state_rx_wait)
                           || (COM_STATE_I == irq_error_pkg::state_wait_data)
                           || (COM_STATE_I == irq_error_pkg::state_receiving); // R11

    // overflow discards every write while it stands
    assign FIFO_WRITE_ACCEPT_O = FIFO_WRITE_I && !FIFO_FULL_I
                                 && !receive_error_flags[irq_error_pkg::overflow_bit]; // R13

    // previous transceiver state, to see entry into wait-for-data
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prev_state <= 3'h0;
        end else begin
            prev_state <= COM_STATE_I;
        end
    end

    assign rx_phase_clear = RECEIVE_CMD_START_I
                            || (TRANSCEIVE_I
                            && (COM_STATE_I == irq_error_pkg::state_wait_data)
                            && (prev_state != irq_error_pkg::state_wait_data)); // R16

    assign illegal_clear = MULTI_FRAME_RECEIVE_I ? ERRORS_TO_FIFO_I : CMD_START_I; // R12

    // error set and clear terms
    always_comb begin
        error_set = 8'h00;
        error_clr = 8'h00;
        error_set[irq_error_pkg::nvm_error_bit]     = NVM_CMD_END_I && NVM_CMD_ERROR_I; // R10
        error_clr[irq_error_pkg::nvm_error_bit]     = NVM_CMD_END_I && !NVM_CMD_ERROR_I; // R10
        error_set[irq_error_pkg::illegal_write_bit] = FIFO_WRITE_I && illegal_state; // R11
        error_clr[irq_error_pkg::illegal_write_bit] = illegal_clear; // R12
        error_set[irq_error_pkg::overflow_bit]      = FIFO_WRITE_I && FIFO_FULL_I; // R13
        error_clr[irq_error_pkg::overflow_bit]      = CMD_START_I;
        error_set[irq_error_pkg::short_frame_bit]   = FRAME_END_I && SOF_VALID_I
                                                      && frame_short; // R14
        error_clr[irq_error_pkg::short_frame_bit]   = rx_phase_clear; // R16
        error_set[irq_error_pkg::no_data_bit]       = TX_REQUEST_I && FIFO_EMPTY_I; // R17
        error_clr[irq_error_pkg::no_data_bit]       = CMD_START_I;
        error_set[irq_error_pkg::collision_bit]     = COLLISION_I;
        error_clr[irq_error_pkg::collision_bit]     = rx_phase_clear;
        error_set[irq_error_pkg::protocol_bit]      = PROTOCOL_ERROR_I;
        error_clr[irq_error_pkg::protocol_bit]      = rx_phase_clear;
        error_set[irq_error_pkg::integrity_bit]     = INTEGRITY_ERROR_I;
        error_clr[irq_error_pkg::integrity_bit]     = rx_phase_clear;
    end

    // set beats clear so a coincident fault is kept
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            receive_error_flags <= irq_error_pkg::error_reset;
        end else begin
            receive_error_flags <= (receive_error_flags & ~error_clr) | error_set;
        end
    end

    // error request fires on a fresh setting of any of its sources
    assign error_request_src = {
        error_set[irq_error_pkg::illegal_write_bit]
            && !receive_error_flags[irq_error_pkg::illegal_write_bit],
        error_set[irq_error_pkg::overflow_bit]
            && !receive_error_flags[irq_error_pkg::overflow_bit],
        error_set[irq_error_pkg::protocol_bit]
            && !receive_error_flags[irq_error_pkg::protocol_bit],
        error_set[irq_error_pkg::no_data_bit]
            && !receive_error_flags[irq_error_pkg::no_data_bit],
        error_set[irq_error_pkg::integrity_bit]
            && !receive_error_flags[irq_error_pkg::integrity_bit]
    }; // R18

    always_comb begin
        core_hw_set = 7'h00;
        core_hw_set[irq_error_pkg::high_alert_bit]    = HIGH_ALERT_I;
        core_hw_set[irq_error_pkg::low_alert_bit]     = LOW_ALERT_I;
        core_hw_set[irq_error_pkg::command_done_bit]  = COMMAND_DONE_I;
        core_hw_set[irq_error_pkg::transmit_done_bit] = TRANSMIT_DONE_I;
        core_hw_set[irq_error_pkg::receive_done_bit]  = receive_done_event; // R15
        core_hw_set[irq_error_pkg::error_request_bit] = |error_request_src; // R18
        core_hw_set[irq_error_pkg::frame_start_bit]   = FRAME_START_I;
    end

    always_comb begin
        timer_hw_set = {CARD_DETECT_I, TIMER_UNDERFLOW_I}; // R3 R4
    end

    // core request flags
    flag_set_clear #(
        .WIDTH (irq_error_pkg::core_flag_bits)
    ) core_flag_bank (
        .clk_i     (MCLK_I),
        .rst_n_i   (ARST_N_I),
        .wr_i      (wr_core_flags),
        .mask_i    (WDATA_I[6:0]),
        .set_dir_i (WDATA_I[irq_error_pkg::set_dir_bit]),
        .hw_set_i  (core_hw_set),
        .flag_o    (core_flags)
    ); // R19

    // card and timer flags; the global bit is not written by software
    flag_set_clear #(
        .WIDTH (irq_error_pkg::timer_flag_bits)
    ) timer_flag_bank (
        .clk_i     (MCLK_I),
        .rst_n_i   (ARST_N_I),
        .wr_i      (wr_timer_flags),
        .mask_i    (WDATA_I[5:0]),
        .set_dir_i (WDATA_I[irq_error_pkg::set_dir_bit]),
        .hw_set_i  (timer_hw_set),
        .flag_o    (timer_flags)
    ); // R1

    // enable registers
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            core_event_enable <= irq_error_pkg::enable_reset;
        end else if (wr_core_enable) begin
            core_event_enable <= WDATA_I;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            timer_event_enable_pin_ctrl <= irq_error_pkg::enable_reset;
        end else if (wr_timer_enable) begin
            timer_event_enable_pin_ctrl <= WDATA_I;
        end
    end

    // global flag follows the enabled requests, one cycle behind the flags
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            global_interrupt_flag <= 1'b0;
        end else begin
            global_interrupt_flag <= |(core_flags & core_event_enable[6:0]) // R6
                                     || |(timer_flags & timer_event_enable_pin_ctrl[5:0]); // R2 R7
        end
    end

    irq_pin_driver pin_driver (
        .clk_i        (MCLK_I),
        .rst_n_i      (ARST_N_I),
        .global_i     (global_interrupt_flag),
        .pin_enable_i (timer_event_enable_pin_ctrl[irq_error_pkg::pin_enable_bit]), // R9
        .invert_i     (core_event_enable[irq_error_pkg::polarity_bit]), // R5
        .push_pull_i  (timer_event_enable_pin_ctrl[irq_error_pkg::pin_style_bit]), // R8
        .pin_o        (IRQ_PIN_O),
        .pin_oe_o     (IRQ_PIN_OE_O)
    ); // R20

    // read data stands only in the cycle after the strobe
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RDATA_O <= irq_error_pkg::rdata_reset;
        end else if (!RD_I) begin
            RDATA_O <= irq_error_pkg::rdata_reset;
        end else begin
            unique case (ADDR_I)
                irq_error_pkg::core_event_flags_addr: begin
                    RDATA_O <= {1'b0, core_flags};
                end
                irq_error_pkg::timer_event_flags_addr: begin
                    RDATA_O <= {1'b0, global_interrupt_flag, timer_flags};
                end
                irq_error_pkg::core_event_enable_addr: begin
                    RDATA_O <= core_event_enable;
                end
                irq_error_pkg::timer_event_enable_addr: begin
                    RDATA_O <= timer_event_enable_pin_ctrl;
                end
                irq_error_pkg::receive_error_addr: begin
                    RDATA_O <= receive_error_flags;
                end
                default: begin
                    RDATA_O <= irq_error_pkg::rdata_reset;
                end
            endcase
        end
    end

endmodule // irq_error_unit

// ===== irq_error_unit_assertions.sv
// port-level checks for the irq and error flag unit
`timescale 1ns/10ps
module irq_error_unit_assertions (
    // clock, reset, register port
    input wire logic        MCLK_I,
    input wire logic        ARST_N_I,
    input wire logic [7:0]  ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [7:0]  RDATA_O,
    // events
    input wire logic [4:0]  TIMER_UNDERFLOW_I,
    input wire logic        NVM_CMD_END_I,
    input wire logic        NVM_CMD_ERROR_I,
    input wire logic        TX_REQUEST_I,
    input wire logic        FIFO_EMPTY_I,
    // fifo and receiver
    input wire logic        FIFO_WRITE_I,
    input wire logic        FIFO_FULL_I,
    input wire logic        FIFO_WRITE_ACCEPT_O,
    input wire logic        FRAME_END_I,
    input wire logic [12:0] FRAME_BITS_I,
    input wire logic        DISTURBANCE_SUPPRESSION_I,
    input wire logic        FRAME_DROP_O,
    // pin
    input wire logic        IRQ_PIN_O,
    input wire logic        IRQ_PIN_OE_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence s_wr(a);
        WR_I && ADDR_I == a;
    endsequence
    sequence s_rd(a);
        RD_I && ADDR_I == a;
    endsequence
    property p_keep(a);
        s_wr(a) ##1 s_rd(a) |=> RDATA_O == $past(WDATA_I, 2);
    endproperty
    a_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside its cycle");
    a_flag_msb: assert property ($past(RD_I) && $past(ADDR_I) inside {8'h06, 8'h07} |-> !RDATA_O[7])
        else $error("flag register bit 7 read as one");
    a_keep_core_en: assert property (p_keep(8'h08))
        else $error("core enable readback wrong");
    a_keep_timer_en: assert property (p_keep(8'h09))
        else $error("timer enable readback wrong");
    a_timer_capture: assert property (TIMER_UNDERFLOW_I != 5'h00 ##2 s_rd(8'h07)
        |=> (RDATA_O[4:0] & $past(TIMER_UNDERFLOW_I, 3)) == $past(TIMER_UNDERFLOW_I, 3))
        else $error("underflow not captured");
    a_nvm_fail: assert property (NVM_CMD_END_I && NVM_CMD_ERROR_I ##2 s_rd(8'h0a) |=> RDATA_O[7])
        else $error("nvm error not flagged");
    a_no_data: assert property (TX_REQUEST_I && FIFO_EMPTY_I ##2 s_rd(8'h0a) |=> RDATA_O[3])
        else $error("empty transmit not flagged");
    a_full_refuse: assert property (FIFO_WRITE_ACCEPT_O |-> FIFO_WRITE_I && !FIFO_FULL_I)
        else $error("write accepted into full fifo");
    a_ovl_discard: assert property (FIFO_WRITE_I && FIFO_FULL_I |=> !FIFO_WRITE_ACCEPT_O)
        else $error("write accepted after overflow");
    a_drop_rule: assert property (FRAME_DROP_O == (FRAME_END_I && (FRAME_BITS_I < 13'h0004
        || DISTURBANCE_SUPPRESSION_I && FRAME_BITS_I < 13'h0018)))
        else $error("frame drop wrong");
    // first edge after release still shows the released reset state
    a_drain_release: assert property ($past(ARST_N_I) && !IRQ_PIN_OE_O |-> IRQ_PIN_O)
        else $error("pin released while low");
endmodule // irq_error_unit_assertions

// ===== host_irq_model.sv
// host view of the interrupt wire with its pull-up
`timescale 1ns/10ps
module host_irq_model (
    // pin from the device
    input  wire logic pin_i,
    input  wire logic pin_oe_i,
    // resolved wire
    output wire logic line_o
);
    // released wire floats up, never keeps the old level
    assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule // host_irq_model

// ===== irq_error_unit_bench.sv
// self-checking bench for the irq and error flag unit
`timescale 1ns/10ps
module irq_error_unit_bench;
    typedef struct packed {logic [7:0] fa, fv, e0, e1; logic g, line, oe;} row_type;
    logic        clk, rst_n, wr, rd, accept, drop, pin, oe, line;
    logic [7:0]  addr, wdata, rdata;
    logic [4:0]  tu;
    logic [12:0] bits;
    logic [2:0]  st;
    logic        hi, lo, cd, td, fs, card, nend, nerr, fw, ff, fe, cs, rcs, trc, crc;
    logic        txr, mfr, etf, fend, sof, sup, tie;
    int          bad_count, n_checks;
    logic [7:0]  raddr [6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h3c};
    logic [13:0] frames [4] = '{14'h0006, 14'h0008, 14'h002f, 14'h0031};
    row_type     rows [9] = '{
        '{8'h07, 8'h81, 8'h00, 8'hc1, 1, 1, 1}, '{8'h07, 8'h81, 8'h80, 8'hc1, 1, 0, 1},
        '{8'h07, 8'h81, 8'h00, 8'h41, 1, 1, 0}, '{8'h07, 8'h81, 8'h80, 8'h41, 1, 0, 1},
        '{8'h07, 8'h81, 8'h00, 8'h81, 1, 0, 1}, '{8'h07, 8'h81, 8'h00, 8'hc2, 0, 0, 1},
        '{8'h07, 8'ha0, 8'h00, 8'he0, 1, 1, 1}, '{8'h07, 8'h90, 8'h00, 8'hd0, 1, 1, 1},
        '{8'h06, 8'hc0, 8'h40, 8'hc0, 1, 1, 1}};
    always #4 clk = ~clk;
    irq_error_unit dut (.MCLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HIGH_ALERT_I(hi), .LOW_ALERT_I(lo),
        .COMMAND_DONE_I(cd), .TRANSMIT_DONE_I(td), .FRAME_START_I(fs), .CARD_DETECT_I(card),
        .TIMER_UNDERFLOW_I(tu), .NVM_CMD_END_I(nend), .NVM_CMD_ERROR_I(nerr),
        .FIFO_WRITE_I(fw), .FIFO_FULL_I(ff), .FIFO_EMPTY_I(fe), .FIFO_WRITE_ACCEPT_O(accept),
        .CMD_START_I(cs), .RECEIVE_CMD_START_I(rcs), .TRANSCEIVE_I(trc), .AUTH_CMD_I(tie),
        .CRC_TX_I(crc), .COM_STATE_I(st), .TX_REQUEST_I(txr), .MULTI_FRAME_RECEIVE_I(mfr),
        .ERRORS_TO_FIFO_I(etf), .FRAME_END_I(fend), .SOF_VALID_I(sof), .FRAME_BITS_I(bits),
        .DISTURBANCE_SUPPRESSION_I(sup), .COLLISION_I(tie), .PROTOCOL_ERROR_I(tie),
        .INTEGRITY_ERROR_I(tie), .FRAME_DROP_O(drop), .IRQ_PIN_O(pin), .IRQ_PIN_OE_O(oe));
    host_irq_model host (.pin_i(pin), .pin_oe_i(oe), .line_o(line));
    task automatic chk(input logic [7:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
    endtask
    task automatic idle();
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, exp);
        bus(1'b0, a, 8'h00);
        idle();
        #1 chk(rdata, exp, "read");
        @(posedge clk);
    endtask
    task automatic frame(input logic [12:0] n, input logic s);
        fend <= 1'b1;
        sof <= 1'b1;
        bits <= n;
        sup <= s;
        #1 chk({7'h00, drop}, {7'h00, n < 13'h0004 || s && n < 13'h0018}, "drop");
        idle();
        fend <= 1'b0;
        idle();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // a hang is cut short here
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        results();
    end
    initial begin
        {clk, rst_n, wr, rd, addr, wdata, tu, bits, st, hi, lo, cd, td, fs, card} = '0;
        {nend, nerr, fw, ff, fe, cs, rcs, trc, crc, txr, mfr, etf, fend, sof, sup, tie} = '0;
        bad_count = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        idle();
        #1 chk({6'h00, pin, oe}, 8'h01, "reset pin");
        foreach (raddr[i]) rdc(raddr[i], 8'h00);
        bus(1'b1, 8'h0a, 8'hff);
        rdc(8'h0a, 8'h00);
        bus(1'b1, 8'h07, 8'hc0);
        rdc(8'h07, 8'h00);
        bus(1'b1, 8'h08, 8'ha5);
        rdc(8'h08, 8'ha5);
        bus(1'b1, 8'h09, 8'h5a);
        rdc(8'h09, 8'h5a);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].fa, rows[i].fv);
            bus(1'b1, 8'h08, rows[i].e0);
            bus(1'b1, 8'h09, rows[i].e1);
            repeat (4) idle();
            #1 chk({6'h00, line, oe}, {6'h00, rows[i].line, rows[i].oe}, "pin");
            rdc(8'h07, {1'b0, rows[i].g, (rows[i].fa == 8'h07) ? rows[i].fv[5:0] : 6'h00});
            bus(1'b1, 8'h06, 8'h7f);
            bus(1'b1, 8'h07, 8'h3f);
        end
        bus(1'b1, 8'h09, 8'h00);
        idle();
        tu <= 5'h1f;
        card <= 1'b1;
        idle();
        tu <= 5'h00;
        card <= 1'b0;
        rdc(8'h07, 8'h3f);
        // hardware set beats a clear in the same cycle
        bus(1'b1, 8'h07, 8'h3f);
        tu <= 5'h04;
        idle();
        tu <= 5'h00;
        rdc(8'h07, 8'h04);
        {hi, lo, cd, td, fs} <= 5'h1f;
        idle();
        {hi, lo, cd, td, fs} <= 5'h00;
        rdc(8'h06, 8'h79);
        bus(1'b1, 8'h06, 8'h7f);
        rdc(8'h06, 8'h00);
        {nend, nerr} <= 2'h3;
        idle();
        nend <= 1'b0;
        rdc(8'h0a, 8'h80);
        {nend, nerr} <= 2'h2;
        idle();
        nend <= 1'b0;
        rdc(8'h0a, 8'h00);
        crc <= 1'b1;
        fw <= 1'b1;
        #1 chk({7'h00, accept}, 8'h01, "accept");
        idle();
        {fw, crc} <= 2'h0;
        rdc(8'h0a, 8'h40);
        rdc(8'h06, 8'h02);
        cs <= 1'b1;
        idle();
        cs <= 1'b0;
        rdc(8'h0a, 8'h00);
        {ff, fw} <= 2'h3;
        #1 chk({7'h00, accept}, 8'h00, "full");
        idle();
        ff <= 1'b0;
        #1 chk({7'h00, accept}, 8'h00, "discard");
        idle();
        {fw, fe, txr} <= 3'h3;
        idle();
        {fe, txr} <= 2'h0;
        rdc(8'h0a, 8'h28);
        cs <= 1'b1;
        idle();
        cs <= 1'b0;
        rdc(8'h0a, 8'h00);
        // multi-frame mode ignores command start
        {mfr, fw} <= 2'h3;
        st <= 3'h7;
        idle();
        {fw, cs} <= 2'h1;
        st <= 3'h0;
        idle();
        cs <= 1'b0;
        rdc(8'h0a, 8'h40);
        etf <= 1'b1;
        idle();
        {etf, mfr} <= 2'h0;
        rdc(8'h0a, 8'h00);
        // auth phase write plus receiver faults, all on one strobe
        {tie, fw} <= 2'h3;
        idle();
        {tie, fw} <= 2'h0;
        rdc(8'h0a, 8'h47);
        {rcs, cs} <= 2'h3;
        idle();
        {rcs, cs} <= 2'h0;
        rdc(8'h0a, 8'h00);
        bus(1'b1, 8'h06, 8'h7f);
        idle();
        foreach (frames[i]) frame(frames[i][13:1], frames[i][0]);
        rdc(8'h0a, 8'h10);
        rdc(8'h06, 8'h04);
        rcs <= 1'b1;
        idle();
        rcs <= 1'b0;
        rdc(8'h0a, 8'h00);
        frame(13'h0002, 1'b0);
        trc <= 1'b1;
        st <= 3'h5;
        idle();
        st <= 3'h6;
        idle();
        trc <= 1'b0;
        rdc(8'h0a, 8'h00);
        // second reset in mid-run
        rst_n <= 1'b0;
        idle();
        rst_n <= 1'b1;
        rdc(8'h08, 8'h00);
        #1 chk({6'h00, pin, oe}, 8'h01, "reset pin");
        results();
    end
endmodule // irq_error_unit_bench
bind irq_error_unit irq_error_unit_assertions checks (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .TIMER_UNDERFLOW_I(TIMER_UNDERFLOW_I), .NVM_CMD_END_I(NVM_CMD_END_I),
    .NVM_CMD_ERROR_I(NVM_CMD_ERROR_I), .TX_REQUEST_I(TX_REQUEST_I), .FIFO_EMPTY_I(FIFO_EMPTY_I),
    .FIFO_WRITE_I(FIFO_WRITE_I), .FIFO_FULL_I(FIFO_FULL_I),
    .FIFO_WRITE_ACCEPT_O(FIFO_WRITE_ACCEPT_O), .FRAME_END_I(FRAME_END_I),
    .FRAME_BITS_I(FRAME_BITS_I), .DISTURBANCE_SUPPRESSION_I(DISTURBANCE_SUPPRESSION_I),
    .FRAME_DROP_O(FRAME_DROP_O), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE_O(IRQ_PIN_OE_O));
